// File: rtl/btc_consts.svh
`ifndef BTC_CONSTS_SVH
`define BTC_CONSTS_SVH
// opcode match patterns on the top bits of the 14-bit word
`define BTC_OP_SKIP_HI    4'h7     // word[13:10] == 4'b0111 (01 11bb)
`define BTC_OP_CALL_HI    3'h4     // word[13:11] == 3'b100
`define BTC_OP_CLR_HI     7'h03    // word[13:7]  == 7'b0000011
// field positions
`define BTC_BIT_MSB       9
`define BTC_BIT_LSB       7
`define BTC_FILE_MSB      6
`define BTC_IMM_MSB       10
`define BTC_LATCH_LSB     3
// reset values
`define BTC_PC_RST        13'h0000
`define BTC_NOP_WORD      14'h0000
`define BTC_CLR_VALUE     8'h00
// cycle counts
`define BTC_CALL_CYCLES   2
`endif

// File: rtl/btc_pkg.sv
package btc_pkg;
  // execution phase, one-hot
  typedef enum logic [2:0] {
    BTC_RUN   = 3'h1,
    BTC_FLUSH = 3'h2,
    BTC_CALL2 = 3'h4
  } btc_phase_t;
  // decoded instruction class
  typedef enum logic [3:0] {
    BTC_DEC_NONE = 4'h1,
    BTC_DEC_SKIP = 4'h2,
    BTC_DEC_CALL = 4'h4,
    BTC_DEC_CLR  = 4'h8
  } btc_dec_t;
endpackage : btc_pkg

// File: rtl/btc_decode.sv
`timescale 1ns/10ps
`include "btc_consts.svh"
module btc_decode
  import btc_pkg::*;
(
  input  wire logic [13:0] word_i,  // instruction word
  output btc_dec_t         class_o, // decoded class
  output logic      [2:0]  bit_o,   // bit select
  output logic      [6:0]  file_o,  // file address
  output logic      [10:0] imm_o    // call target
);
  // classify by top opcode bits
  always_comb begin
    if (word_i[13:10] == `BTC_OP_SKIP_HI) begin
      class_o = BTC_DEC_SKIP;
    end else if (word_i[13:11] == `BTC_OP_CALL_HI) begin
      class_o = BTC_DEC_CALL;
    end else if (word_i[13:7] == `BTC_OP_CLR_HI) begin
      class_o = BTC_DEC_CLR;
    end else begin
      class_o = BTC_DEC_NONE;
    end
  end
  // operand fields
  assign bit_o  = word_i[`BTC_BIT_MSB:`BTC_BIT_LSB];
  assign file_o = word_i[`BTC_FILE_MSB:0];
  assign imm_o  = word_i[`BTC_IMM_MSB:0];
endmodule : btc_decode

// File: rtl/btc_exec.sv
`timescale 1ns/10ps
`include "btc_consts.svh"
// Operation
// - skip next when tested bit set
// - taken skip flushes prefetch, runs no-op
// - call pushes pc plus one
// - call loads immediate into pc low
// - call upper pc from high latch
// - call takes exactly two cycles
// - clear writes zero, sets zero flag
module btc_exec
  import btc_pkg::*;
#(
  parameter int PC_W = 13  // program counter width
) (
  input  wire logic            core_clk_i,          // 10 MHz instruction clock
  input  wire logic            srst_i,              // sync reset, high
  input  wire logic [13:0]     instr_i,             // prefetched word in execute
  input  wire logic            instr_valid_i,       // word is meaningful
  input  wire logic [7:0]      file_rdata_i,        // addressed file register
  input  wire logic [7:0]      pc_high_latch_i,     // latch register value
  output logic      [6:0]      file_addr_o,         // file register address
  output logic                 file_we_o,           // file write strobe
  output logic      [7:0]      file_wdata_o,        // file write data
  output logic                 zero_set_o,          // set zero flag
  output logic                 push_o,              // return stack push
  output logic      [PC_W-1:0] return_stack_top_o,  // pushed address
  output logic      [PC_W-1:0] pc_o,                // program counter
  output logic                 flush_o,             // discarding prefetch
  output logic                 busy_o               // call second cycle in progress
);
  // refuse widths the latch and immediate cannot fill
  if (PC_W != 13) begin : g_pc_w_bad
    $error("PC_W must be 13");
  end

  //////////////////////////////////////////////////////////////////////
  // block state, one packed word
  typedef struct packed {
    btc_phase_t      phase;
    logic [PC_W-1:0] pc;
    logic [PC_W-1:0] ret_top;
    logic            push;
    logic            we;
    logic [6:0]      addr;
    logic            zset;
  } btc_state_t;

  // state copies and decoded fields
  btc_state_t s_q, s_d;
  btc_dec_t   cls;
  logic [2:0] bsel;
  logic [6:0] fsel;
  logic [10:0] imm;

  // opcode and operand decode
  btc_decode u_dec (
    .word_i  (instr_i),
    .class_o (cls),
    .bit_o   (bsel),
    .file_o  (fsel),
    .imm_o   (imm)
  );

  //////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    s_d      = s_q;
    s_d.push = 1'b0;
    s_d.we   = 1'b0;
    s_d.zset = 1'b0;
    s_d.addr = fsel;
    case (s_q.phase)
      BTC_RUN: begin
        s_d.pc = s_q.pc + 13'h0001;
        if (instr_valid_i) begin
          case (cls)
            BTC_DEC_SKIP: begin
              if (file_rdata_i[bsel]) s_d.phase = BTC_FLUSH;
            end
            BTC_DEC_CALL: begin
              s_d.push = 1'b1;
              s_d.ret_top = s_q.pc + 13'h0001;
              s_d.pc    = {pc_high_latch_i[`BTC_LATCH_LSB+1:`BTC_LATCH_LSB], imm};
              s_d.phase = BTC_CALL2;
            end
            BTC_DEC_CLR: begin
              s_d.we   = 1'b1;
              s_d.zset = 1'b1;
            end
            default: begin
            end
          endcase
        end
      end
      BTC_FLUSH: begin
        // discarded word behaves as no-op
        s_d.pc    = s_q.pc + 13'h0001;
        s_d.phase = BTC_RUN;
      end
      BTC_CALL2: begin
        // target fetch cycle, pc holds target
        s_d.phase = BTC_RUN;
      end
      default: s_d.phase = BTC_RUN;
    endcase
  end

  // state register
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      s_q       <= '0;
      s_q.phase <= BTC_RUN;
      s_q.pc    <= `BTC_PC_RST;
    end else begin
      s_q <= s_d;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // outputs
  assign file_addr_o        = s_q.addr;
  assign file_we_o          = s_q.we;
  assign file_wdata_o       = `BTC_CLR_VALUE;
  assign zero_set_o         = s_q.zset;
  assign push_o             = s_q.push;
  assign return_stack_top_o = s_q.ret_top;
  assign pc_o               = s_q.pc;
  assign flush_o            = (s_q.phase != BTC_RUN);
  assign busy_o             = (s_q.phase == BTC_CALL2);

  //////////////////////////////////////////////////////////////////////
  // checks
  // taken skip flushes
  a_skip_taken: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (s_q.phase == BTC_RUN && instr_valid_i && cls == BTC_DEC_SKIP && file_rdata_i[bsel])
    |=> flush_o ##1 !flush_o) else $error("taken skip did not flush one cycle");

  a_skip_nop: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (s_q.phase == BTC_FLUSH) |-> ##1 (!file_we_o && !push_o))
    else $error("flushed word had effect");

  a_call_push: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (s_q.phase == BTC_RUN && instr_valid_i && cls == BTC_DEC_CALL)
    |=> push_o && return_stack_top_o == $past(s_q.pc) + 13'h0001)
    else $error("call pushed wrong address");

  a_call_low: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (s_q.phase == BTC_RUN && instr_valid_i && cls == BTC_DEC_CALL)
    |=> pc_o[10:0] == $past(instr_i[10:0])) else $error("call low pc wrong");

  a_call_high: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (s_q.phase == BTC_RUN && instr_valid_i && cls == BTC_DEC_CALL)
    |=> pc_o[12:11] == $past(pc_high_latch_i[4:3])) else $error("call high pc wrong");

  a_call_two: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (s_q.phase == BTC_RUN && instr_valid_i && cls == BTC_DEC_CALL)
    |=> busy_o ##1 !busy_o) else $error("call not two cycles");

  a_clear_zero: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (s_q.phase == BTC_RUN && instr_valid_i && cls == BTC_DEC_CLR)
    |=> file_we_o && zero_set_o && file_wdata_o == 8'h00
        && file_addr_o == $past(instr_i[6:0])) else $error("clear wrong");

  a_one_cycle: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (s_q.phase == BTC_RUN && instr_valid_i && (cls == BTC_DEC_CLR
     || (cls == BTC_DEC_SKIP && !file_rdata_i[bsel])))
    |=> !flush_o && pc_o == $past(pc_o) + 13'h0001) else $error("not single cycle");

  a_flush_advance: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (s_q.phase == BTC_FLUSH) |=> !flush_o && pc_o == $past(pc_o) + 13'h0001)
    else $error("flush cycle did not advance pc");

  a_flush_tos: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (s_q.phase == BTC_FLUSH) |=> return_stack_top_o == $past(return_stack_top_o))
    else $error("flushed word changed return address");

  a_skip_clean: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (s_q.phase == BTC_RUN && instr_valid_i && cls == BTC_DEC_SKIP && file_rdata_i[bsel])
    |=> !push_o && !file_we_o && pc_o == $past(pc_o) + 13'h0001)
    else $error("taken skip had side effect");

  a_push_once: assert property (@(posedge core_clk_i) disable iff (srst_i)
    push_o |=> !push_o) else $error("push held two cycles");

  a_tos_hold: assert property (@(posedge core_clk_i) disable iff (srst_i)
    !(s_q.phase == BTC_RUN && instr_valid_i && cls == BTC_DEC_CALL)
    |=> return_stack_top_o == $past(return_stack_top_o))
    else $error("return address moved");

  a_call_hold: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (s_q.phase == BTC_CALL2) |=> !push_o && !flush_o && pc_o == $past(pc_o))
    else $error("call second cycle moved pc");

  a_busy_flush: assert property (@(posedge core_clk_i) disable iff (srst_i)
    busy_o |-> flush_o) else $error("busy without flush");

  a_zero_pair: assert property (@(posedge core_clk_i) disable iff (srst_i)
    zero_set_o == file_we_o) else $error("zero flag apart from clear write");

  a_idle_advance: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (s_q.phase == BTC_RUN && !instr_valid_i)
    |=> !flush_o && !push_o && !file_we_o && pc_o == $past(pc_o) + 13'h0001)
    else $error("idle cycle wrong");
endmodule : btc_exec

// File: dv/bit_test_call_clear_exec_bench.sv
`timescale 1ns/10ps
module bit_test_call_clear_exec_bench;
  logic        core_clk_i      = 1'b0;
  logic        srst_i          = 1'b1;
  logic        instr_valid_i   = 1'b0;
  logic [13:0] instr_i         = 14'h0000;
  logic [7:0]  file_rdata_i    = 8'h00;
  logic [7:0]  pc_high_latch_i = 8'h00;
  logic [7:0]  file_wdata_o;
  logic [6:0]  file_addr_o;
  logic        file_we_o, zero_set_o, push_o, flush_o, busy_o;
  logic [12:0] return_stack_top_o, pc_o;
  int          mismatches = 0, n_compared = 0, seed = 32'hb0b8, rst_cnt = 19, mode = 0;
  int          ph, pc, ret_top, addr, push, we, fl, bsy, live = 0;
  logic [13:0] w;
  logic [31:0] r;

  btc_exec btc_exec_i (.core_clk_i(core_clk_i), .srst_i(srst_i), .instr_i(instr_i),
    .instr_valid_i(instr_valid_i), .file_rdata_i(file_rdata_i),
    .pc_high_latch_i(pc_high_latch_i), .file_addr_o(file_addr_o), .file_we_o(file_we_o),
    .file_wdata_o(file_wdata_o), .zero_set_o(zero_set_o), .push_o(push_o),
    .return_stack_top_o(return_stack_top_o), .pc_o(pc_o), .flush_o(flush_o), .busy_o(busy_o));

  ////////////////////////////////////////////////////////////////////////////
  // clock and watchdog
  initial begin
    forever #50 core_clk_i = ~core_clk_i;
  end
  initial begin
    repeat (3000) @(posedge core_clk_i);
    mismatches++;
    wrap_up();
  end

  task chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    n_compared++;
    if (s !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  // word of class k: skip, call, clear, other
  function automatic logic [13:0] gen(input int k, input logic [31:0] v);
    case (k)
      0: return {4'h7, v[9:0]};
      1: return {3'h4, v[10:0]};
      2: return {7'h03, v[6:0]};
      default: return {4'h4, v[9:0]};
    endcase
  endfunction : gen

  ////////////////////////////////////////////////////////////////////////////
  // reference model, then next stimulus
  always @(posedge core_clk_i) begin
    live = 1;
    push = 0; we = 0; fl = 0; bsy = 0;
    if (srst_i) begin
      ph = 0; pc = 0; ret_top = 0; addr = 0;
    end else if (ph != 0) begin
      if (ph == 1) pc = (pc + 1) & 32'h1fff;
      ph = 0;
    end else if (!instr_valid_i) begin
      // idle run cycle still advances pc
      pc = (pc + 1) & 32'h1fff;
    end else begin
      w = instr_i;
      addr = w[6:0];
      pc = (pc + 1) & 32'h1fff;
      if (w[13:10] == 4'h7 && file_rdata_i[w[9:7]]) begin
        fl = 1; ph = 1;
      end else if (w[13:11] == 3'h4) begin
        push = 1; ret_top = pc; fl = 1; bsy = 1; ph = 2;
        pc = {pc_high_latch_i[4:3], w[10:0]};
      end else if (w[13:7] == 7'h03) begin
        we = 1;
      end
    end
    r = $random(seed);
    srst_i <= (rst_cnt > 0);
    if (rst_cnt > 0) rst_cnt--;
    instr_i <= gen((mode < 3 && r[13]) ? mode : int'(r[12:11]), r);
    instr_valid_i <= (ph != 0) ? r[14] : (r[14] | r[31]);
    file_rdata_i <= r[22:15];
    pc_high_latch_i <= r[30:23];
  end

  ////////////////////////////////////////////////////////////////////////////
  // compare settled outputs
  always @(negedge core_clk_i) begin
    if (live) begin
      chk("pc", pc_o, pc);
      chk("ret_top", return_stack_top_o, ret_top);
      chk("push", push_o, push);
      chk("flush", flush_o, fl);
      chk("busy", busy_o, bsy);
      chk("we", file_we_o, we);
      chk("zero", zero_set_o, we);
      if (we || ph == 1) chk("addr", file_addr_o, addr);
      if (we) chk("wdata", file_wdata_o, 16'h0000);
    end
  end

  initial begin
    repeat (21) @(posedge core_clk_i);
    for (int t = 0; t < 4; t++) begin
      @(negedge core_clk_i);
      mode = t;
      rst_cnt = 2;
      repeat (400) @(posedge core_clk_i);
      $display("test %0d done, %0d compared", t, n_compared);
    end
    wrap_up();
  end

  task wrap_up();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : wrap_up
endmodule : bit_test_call_clear_exec_bench
